// File: rtl/wdt_core.sv
// watchdog timer with write-only config and command-code registers, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module wdt_core #(
   parameter int FC_TAP = wdt_pkg::FC_TAP_MSB, // fast divider tap msb
   parameter int FS_TAP = wdt_pkg::FS_TAP_MSB, // slow divider tap msb
   parameter int LF_DIV = wdt_pkg::LF_RATIO    // system clocks per slow tick
) (
   input  wire logic        hclk,           // 200 MHz clock
   input  wire logic        hresetn,        // async reset, active low
   input  wire logic        hsel,           // slave select
   input  wire logic [31:0] haddr,          // address
   input  wire logic [1:0]  htrans,         // transfer type
   input  wire logic        hwrite,         // write strobe
   input  wire logic [2:0]  hsize,          // transfer size
   input  wire logic [31:0] hwdata,         // write data
   input  wire logic        hready,         // bus ready in
   output logic             hreadyout,      // slave ready
   output logic [31:0]      hrdata,         // read data
   output logic             hresp,          // response, always okay
   output logic             wdog_rst_req,   // reset request, active high
   output logic             wdog_irq,       // non-maskable interrupt pulse
   output logic             trap_ram_sel,   // committed ram trap select
   output logic             trap_action_sel // trap action select
);
   import wdt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic        ap_valid;
   logic        wr_pend_ff;
   logic [11:0] wr_addr_ff;
   logic        wr_cfg;
   logic        wr_cmd;
   logic        wr_mode;
   logic [7:0]  wd;
   logic [7:0]  cfg_ff;
   logic [7:0]  nxt_cfg;
   logic [2:0]  mode_ff;
   logic        run_ff;
   logic        nxt_run;
   logic        trap_ram_ff;
   logic        clear_ff;
   logic        irq_ff;
   logic        rst_req_ff;
   logic [4:0]  rst_cnt_ff;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic        hreadyout_ff;
   logic        hresp_ff;
   logic        ovf;

   wdt_cnt_if cif ();

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite address phase capture
   assign ap_valid = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 12'h000;
      end else begin
         wr_pend_ff <= ap_valid && hwrite;
         if (ap_valid) begin
            wr_addr_ff <= haddr[11:0];
         end
      end
   end

   // data phase write decode; unmapped addresses are ignored
   assign wr_cfg  = wr_pend_ff && (wr_addr_ff == ADDR_CONFIG);
   assign wr_cmd  = wr_pend_ff && (wr_addr_ff == ADDR_COMMAND);
   assign wr_mode = wr_pend_ff && (wr_addr_ff == ADDR_MODE);
   assign wd      = hwdata[7:0];

   // zero wait states, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end else begin
         hreadyout_ff <= 1'b1;
         hresp_ff     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // configuration register
   always_comb begin
      nxt_cfg = cfg_ff;
      if (wr_cfg) begin
         nxt_cfg = wd;
         // once interrupt is chosen it can never go back to reset
         nxt_cfg[CFG_ACTION] = wd[CFG_ACTION] & cfg_ff[CFG_ACTION];
         nxt_cfg[7:6] = 2'h3;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_ff <= CFG_RESET;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode control: prescale source, slow mode, stop/idle/sleep hold
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ff <= MODE_RESET;
      end else if (wr_mode) begin
         mode_ff <= wd[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // run state: enable bit starts it, disable code stops it only while the enable bit is clear
   always_comb begin
      nxt_run = run_ff;
      if (wr_cfg && wd[CFG_ENABLE]) begin
         nxt_run = 1'b1;
      end else if (wr_cmd && (wd == CMD_DISABLE) && !cfg_ff[CFG_ENABLE]) begin
         nxt_run = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_ff <= 1'b1;
      end else begin
         run_ff <= nxt_run;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command codes: clear and trap commit; disable is decoded in the run state; other codes do nothing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clear_ff <= 1'b0;
      end else begin
         clear_ff <= wr_cmd && (wd == CMD_CLEAR);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trap_ram_ff <= 1'b1;
      end else if (wr_cmd && (wd == CMD_TRAP)) begin
         trap_ram_ff <= cfg_ff[CFG_TRAP_RAM];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // counter chain
   assign cif.hold   = mode_ff[MODE_HOLD];
   assign cif.lf_sel = mode_ff[MODE_PRESCALE] | mode_ff[MODE_SLOW];
   assign cif.run    = run_ff;
   assign cif.clear  = clear_ff || rst_req_ff;
   assign cif.tsel   = cfg_ff[CFG_TSEL_LO +: 2];
   assign ovf        = cif.ovf;

   wdt_count #(
      .FC_TAP (FC_TAP),
      .FS_TAP (FS_TAP),
      .LF_DIV (LF_DIV)
   ) u_count (
      .hclk    (hclk),
      .hresetn (hresetn),
      .cif     (cif.cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // overflow action: interrupt pulse, not gated by any master flag
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= ovf && !cfg_ff[CFG_ACTION];
      end
   end

   // reset request held for a fixed number of fast clock periods
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rst_req_ff <= 1'b0;
         rst_cnt_ff <= 5'h00;
      end else if (rst_req_ff) begin
         if (rst_cnt_ff == 5'(RST_CYCLES - 1)) begin
            rst_req_ff <= 1'b0;
            rst_cnt_ff <= 5'h00;
         end else begin
            rst_cnt_ff <= rst_cnt_ff + 5'h01;
         end
      end else if (ovf && cfg_ff[CFG_ACTION]) begin
         rst_req_ff <= 1'b1;
         rst_cnt_ff <= 5'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data, prepared in the address phase
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (haddr[11:0])
         ADDR_MODE: begin
            nxt_rdata = {29'h0, mode_ff};
         end
         ADDR_STATUS: begin
            nxt_rdata = {26'h0, trap_ram_ff, rst_req_ff, cfg_ff[CFG_ACTION],
                         cif.bincnt, run_ff};
         end
         default: begin
            // config and command are write-only and read as zero
            nxt_rdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_ff <= 32'h0000_0000;
      end else if (ap_valid && !hwrite) begin
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign hreadyout       = hreadyout_ff;
   assign hresp           = hresp_ff;
   assign hrdata          = rdata_ff;
   assign wdog_rst_req    = rst_req_ff;
   assign wdog_irq        = irq_ff;
   assign trap_ram_sel    = trap_ram_ff;
   assign trap_action_sel = cfg_ff[CFG_TRAP_ACT];
endmodule : wdt_core
`default_nettype wire

// File: rtl/wdt_pkg.sv
// constants, offsets and codes shared by the watchdog timer files
package wdt_pkg;
   // register indices and byte addresses (byte address is four times the index)
   localparam logic [7:0]  IDX_CONFIG   = 8'h34;
   localparam logic [7:0]  IDX_COMMAND  = 8'h35;
   localparam logic [7:0]  IDX_MODE     = 8'h36;
   localparam logic [7:0]  IDX_STATUS   = 8'h37;
   localparam logic [11:0] ADDR_CONFIG  = {2'h0, IDX_CONFIG, 2'h0};
   localparam logic [11:0] ADDR_COMMAND = {2'h0, IDX_COMMAND, 2'h0};
   localparam logic [11:0] ADDR_MODE    = {2'h0, IDX_MODE, 2'h0};
   localparam logic [11:0] ADDR_STATUS  = {2'h0, IDX_STATUS, 2'h0};
   // watchdog_config field positions
   localparam int CFG_ACTION    = 0;
   localparam int CFG_TSEL_LO   = 1;
   localparam int CFG_ENABLE    = 3;
   localparam int CFG_TRAP_ACT  = 4;
   localparam int CFG_TRAP_RAM  = 5;
   localparam logic [7:0] CFG_RESET = 8'h39;
   // mode_ctrl field positions
   localparam int MODE_PRESCALE = 0;
   localparam int MODE_SLOW     = 1;
   localparam int MODE_HOLD     = 2;
   localparam logic [2:0] MODE_RESET = 3'h0;
   // command codes
   localparam logic [7:0] CMD_CLEAR   = 8'h4e;
   localparam logic [7:0] CMD_DISABLE = 8'hb1;
   localparam logic [7:0] CMD_TRAP    = 8'hd2;
   // divider taps: tap msb + 1 + two counter stages gives the overflow exponent
   localparam int DIV_W       = 23;
   localparam int FC_TAP_MSB  = 22;
   localparam int FS_TAP_MSB  = 14;
   localparam int LF_RATIO    = 6104;
   // reset request length
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int FC_PERIOD_PS   = 5000;
   localparam int RST_TIME_PS    = 24 * FC_PERIOD_PS;
   localparam int RST_CYCLES     = RST_TIME_PS / CLK_PERIOD_PS;
   typedef logic [1:0] wdt_tsel_t;
endpackage : wdt_pkg

// File: rtl/wdt_cnt_if.sv
// interface between the watchdog control logic and its counter chain
`timescale 1ns/1ps
`default_nettype none
interface wdt_cnt_if;
   import wdt_pkg::*;
   logic      hold;    // pause divider and counter
   logic      lf_sel;  // count low-frequency ticks
   logic      run;     // watchdog enabled
   logic      clear;   // clear binary counter
   wdt_tsel_t tsel;    // detection time select
   logic      ovf;     // overflow pulse
   logic [1:0] bincnt; // binary counter value
   modport ctrl (output hold, lf_sel, run, clear, tsel, input ovf, bincnt);
   modport cnt  (input hold, lf_sel, run, clear, tsel, output ovf, bincnt);
endinterface : wdt_cnt_if
`default_nettype wire

// File: rtl/wdt_count.sv
// internal divider and two-stage binary counter of the watchdog
`timescale 1ns/1ps
`default_nettype none
module wdt_count #(
   parameter int FC_TAP   = wdt_pkg::FC_TAP_MSB,
   parameter int FS_TAP   = wdt_pkg::FS_TAP_MSB,
   parameter int LF_DIV   = wdt_pkg::LF_RATIO
) (
   input  wire logic hclk,    // system clock
   input  wire logic hresetn, // async reset, active low
   wdt_cnt_if.cnt    cif      // control side
);
   import wdt_pkg::*;

   logic [15:0]      lf_cnt_ff;
   logic             lf_tick;
   logic             src_tick;
   logic [DIV_W-1:0] div_ff;
   logic [DIV_W-1:0] mask;
   logic [4:0]       tap;
   logic             carry;
   logic [1:0]       bin_ff;
   logic             ovf_ff;

   ////////////////////////////////////////////////////////////////////////////
   // low-frequency tick derived from the system clock
   assign lf_tick = (lf_cnt_ff == 16'(LF_DIV - 1));
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lf_cnt_ff <= 16'h0000;
      end else if (lf_tick) begin
         lf_cnt_ff <= 16'h0000;
      end else begin
         lf_cnt_ff <= lf_cnt_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // free-running divider; never cleared by the clear code
   assign src_tick = !cif.hold && (cif.lf_sel ? lf_tick : 1'b1);
   assign tap      = 5'(cif.lf_sel ? FS_TAP : FC_TAP) - {2'h0, cif.tsel, 1'b0};
   assign mask     = ~({DIV_W{1'b1}} << (tap + 5'h01));
   assign carry    = src_tick && ((div_ff & mask) == mask);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_ff <= '0;
      end else if (src_tick) begin
         div_ff <= div_ff + DIV_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // two-stage binary counter, cleared by command or while disabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bin_ff <= 2'h0;
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= 1'b0;
         if (cif.clear || !cif.run) begin
            bin_ff <= 2'h0;
         end else if (carry) begin
            bin_ff <= bin_ff + 2'h1;
            ovf_ff <= (bin_ff == 2'h3);
         end
      end
   end

   assign cif.ovf    = ovf_ff;
   assign cif.bincnt = bin_ff;
endmodule : wdt_count
`default_nettype wire

// File: test/wdt_core_properties.sv
// port-level assertions for the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
module wdt_core_properties
   import wdt_pkg::*;
(
   input wire logic        hclk,           // clock
   input wire logic        hresetn,        // reset, active low
   input wire logic        hsel,           // slave select
   input wire logic [31:0] haddr,          // address
   input wire logic [1:0]  htrans,         // transfer type
   input wire logic        hwrite,         // write strobe
   input wire logic [31:0] hwdata,         // write data
   input wire logic        hready,         // bus ready
   input wire logic [31:0] hrdata,         // read data
   input wire logic        hresp,          // response
   input wire logic        wdog_rst_req,   // reset request
   input wire logic        wdog_irq,       // interrupt pulse
   input wire logic        trap_ram_sel,   // committed trap select
   input wire logic        trap_action_sel // trap action select
);
   ////////////////////////////////////////////////////////////
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [7:0] rst_len_ff;
   wire logic  take   = hsel && hready && htrans[1];
   wire logic  wr_cfg = take && hwrite && haddr[11:0] == ADDR_CONFIG;
   wire logic  wr_cmd = take && hwrite && haddr[11:0] == ADDR_COMMAND;
   wire logic  rd_cfg = take && !hwrite && haddr[11:0] == ADDR_CONFIG;
   // cycles the reset request has been high so far
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         rst_len_ff <= 8'h0;
      else if (wdog_rst_req)
         rst_len_ff <= rst_len_ff + 8'h1;
      else
         rst_len_ff <= 8'h0;
   end
   a_cfg_read_zero:
      assert property (rd_cfg |=> hrdata == 32'h0) else $error("config read not zero");
   a_resp_okay:
      assert property (hresp == 1'b0) else $error("error response");
   a_trap_act_copy:
      assert property (wr_cfg |=> ##1 trap_action_sel == $past(hwdata[CFG_TRAP_ACT]))
      else $error("trap action not taken from config");
   a_trap_commit_only:
      assert property (!$stable(trap_ram_sel) |-> $past(wr_cmd, 2)
                       && $past(hwdata[7:0]) == CMD_TRAP)
      else $error("trap select changed without commit");
   a_irq_one_pulse:
      assert property (wdog_irq |=> !wdog_irq) else $error("interrupt over one cycle");
   a_irq_not_rst:
      assert property (wdog_irq |-> !wdog_rst_req) else $error("interrupt with reset");
   a_rst_len_max:
      assert property (rst_len_ff <= RST_CYCLES) else $error("reset request too long");
   a_rst_len_full:
      assert property ($fell(wdog_rst_req) |-> rst_len_ff == RST_CYCLES)
      else $error("reset request cut short");
endmodule : wdt_core_properties
bind wdt_core wdt_core_properties wdt_core_properties_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hresp(hresp),
   .wdog_rst_req(wdog_rst_req), .wdog_irq(wdog_irq), .trap_ram_sel(trap_ram_sel),
   .trap_action_sel(trap_action_sel)
);
`default_nettype wire

// File: test/watchdog_timer_with_code_register_test.sv
// self-checking bench for the watchdog timer block
`timescale 1ns/1ps
`default_nettype none
module watchdog_timer_with_code_register_test;
   import wdt_pkg::*;
   localparam int FAST_TAP = 6;
   localparam int SLOW_TAP = 6;
   localparam int SLOW_DIV = 4;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rst_q;
   logic        wdog_rst_req, wdog_irq, trap_ram_sel, trap_action_sel;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, r, r2;
   int          failures = 0;
   int          cmp_count = 0;
   int          irq_n = 0;
   int          rst_n = 0;
   int          n, k;
   ////////////////////////////////////////////////////////////
   wdt_core #(.FC_TAP(FAST_TAP), .FS_TAP(SLOW_TAP), .LF_DIV(SLOW_DIV)) wdt_core_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .wdog_rst_req(wdog_rst_req),
      .wdog_irq(wdog_irq), .trap_ram_sel(trap_ram_sel), .trap_action_sel(trap_action_sel)
   );
   always #2.5 hclk = ~hclk;
   // event counts, sampled like a flop
   always @(posedge hclk) begin
      if (wdog_irq === 1'b1)
         irq_n++;
      if (wdog_rst_req === 1'b1 && rst_q !== 1'b1)
         rst_n++;
      rst_q = wdog_rst_req;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : final_report
   task automatic wait_ready();
      int c;
      c = 0;
      do begin
         @(posedge hclk);
         c++;
      end while (hreadyout !== 1'b1 && c < 20);
      if (hreadyout !== 1'b1) begin
         failures++;
         final_report();
      end
   endtask : wait_ready
   // one single transfer; read data lands in r
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_ready();
      r = hrdata;
   endtask : bus
   function automatic logic [7:0] cfg(input logic ram, input logic at, input logic en,
                                      input logic [1:0] ts, input logic act);
      cfg = {2'b11, ram, at, en, ts, act};
   endfunction : cfg
   // waits for the next overflow event and checks its time and kind
   task automatic wait_ovf(input int m, input int ts, input logic want_rst, input logic full);
      int p, g, c;
      g = m == 0 ? 1 : SLOW_DIV;
      p = 4 * (2 ** ((m == 0 ? FAST_TAP : SLOW_TAP) - 2 * ts + 1)) * g;
      c = 0;
      while (wdog_irq !== 1'b1 && wdog_rst_req !== 1'b1 && c <= p + 4 * g + 4) begin
         @(posedge hclk);
         c++;
      end
      check({31'h0, c >= (full ? p * 3 / 4 - 2 * g : 0)}, 32'h1);
      check({31'h0, c <= p + 4 * g + 4}, 32'h1);
      check({30'h0, wdog_rst_req, wdog_irq}, want_rst ? 32'h2 : 32'h1);
      if (c > p + 4 * g + 4)
         final_report();
      repeat (RST_CYCLES + 2) @(posedge hclk);
   endtask : wait_ovf
   initial begin
      repeat (50000) @(posedge hclk);
      failures++;
      final_report();
   end
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      void'($urandom(14));
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      check({28'h0, trap_ram_sel, trap_action_sel, wdog_irq, wdog_rst_req}, 32'hc);
      bus(1'b0, ADDR_STATUS, 8'h0);
      check(r & 32'h9, 32'h9);
      wait_ovf(0, 0, 1'b1, 1'b1);
      $display("test reset defaults done");
      for (int m = 0; m < 3; m++) begin
         for (int ts = 0; ts < 4; ts++) begin
            k = $urandom_range(3);
            // clear first so a short old period cannot overflow during setup
            bus(1'b1, ADDR_COMMAND, CMD_CLEAR);
            bus(1'b1, ADDR_CONFIG, cfg(k[1], k[0], 1'b1, ts[1:0], 1'b1));
            bus(1'b1, ADDR_MODE, m[7:0]);
            bus(1'b1, ADDR_COMMAND, CMD_CLEAR);
            wait_ovf(m, ts, 1'b1, 1'b1);
            check({31'h0, trap_action_sel}, {31'h0, k[0]});
         end
      end
      $display("test detection times done");
      bus(1'b1, ADDR_MODE, 8'h0);
      bus(1'b1, ADDR_CONFIG, cfg(1'b1, 1'b1, 1'b1, 2'h2, 1'b1));
      n = rst_n;
      repeat (10) begin
         bus(1'b1, ADDR_COMMAND, CMD_CLEAR);
         repeat (16) @(posedge hclk);
      end
      check(rst_n, n);
      $display("test periodic clearing done");
      bus(1'b1, ADDR_COMMAND, CMD_CLEAR);
      bus(1'b1, ADDR_CONFIG, cfg(1'b1, 1'b1, 1'b1, 2'h3, 1'b1));
      bus(1'b1, ADDR_COMMAND, CMD_CLEAR);
      bus(1'b1, ADDR_MODE, 8'h4);
      n = rst_n;
      bus(1'b0, ADDR_STATUS, 8'h0);
      r2 = r;
      repeat (60) @(posedge hclk);
      bus(1'b0, ADDR_STATUS, 8'h0);
      check(r & 32'h6, r2 & 32'h6);
      check(rst_n, n);
      bus(1'b1, ADDR_MODE, 8'h0);
      wait_ovf(0, 3, 1'b1, 1'b0);
      $display("test pause and resume done");
      // clear before choosing the interrupt so the running count cannot fire early
      bus(1'b1, ADDR_COMMAND, CMD_CLEAR);
      bus(1'b1, ADDR_CONFIG, cfg(1'b1, 1'b1, 1'b1, 2'h3, 1'b0));
      bus(1'b1, ADDR_COMMAND, CMD_CLEAR);
      wait_ovf(0, 3, 1'b0, 1'b1);
      n = irq_n;
      repeat (80) @(posedge hclk); // no clear in answer to the interrupt
      check({31'h0, (irq_n - n) inside {[9:11]}}, 32'h1);
      bus(1'b1, ADDR_CONFIG, cfg(1'b1, 1'b1, 1'b1, 2'h3, 1'b1));
      bus(1'b0, ADDR_STATUS, 8'h0);
      check(r & 32'h8, 32'h0);
      n = rst_n;
      repeat (40) @(posedge hclk);
      check(rst_n, n);
      $display("test interrupt action done");
      bus(1'b1, ADDR_COMMAND, CMD_DISABLE);
      bus(1'b0, ADDR_STATUS, 8'h0);
      check(r & 32'h1, 32'h1);
      bus(1'b1, ADDR_COMMAND, CMD_CLEAR);
      bus(1'b1, ADDR_CONFIG, cfg(1'b0, 1'b1, 1'b0, 2'h3, 1'b0));
      repeat (4) begin
         k = $urandom_range(255);
         if (k == CMD_CLEAR || k == CMD_DISABLE || k == CMD_TRAP)
            k = 0;
         bus(1'b1, ADDR_COMMAND, k[7:0]);
      end
      n = irq_n;
      repeat (20) @(posedge hclk);
      check({31'h0, irq_n > n}, 32'h1);
      bus(1'b0, ADDR_STATUS, 8'h0);
      check(r & 32'h1, 32'h1);
      bus(1'b1, ADDR_COMMAND, CMD_DISABLE);
      repeat (4) @(posedge hclk);
      n = irq_n;
      repeat (50) @(posedge hclk);
      bus(1'b0, ADDR_STATUS, 8'h0);
      check(r & 32'h7, 32'h0);
      check(irq_n, n);
      check({31'h0, trap_ram_sel}, 32'h1);
      bus(1'b1, ADDR_COMMAND, CMD_TRAP);
      repeat (2) @(posedge hclk);
      check({31'h0, trap_ram_sel}, 32'h0);
      bus(1'b1, ADDR_CONFIG, cfg(1'b0, 1'b1, 1'b1, 2'h3, 1'b0));
      bus(1'b0, ADDR_STATUS, 8'h0);
      check(r & 32'h1, 32'h1);
      bus(1'b0, ADDR_CONFIG, 8'h0);
      check(r, 32'h0);
      bus(1'b0, 12'h100, 8'h0);
      check(r, 32'h0);
      $display("test disable and trap done");
      final_report();
   end
endmodule : watchdog_timer_with_code_register_test
`default_nettype wire
